//--- hdl/oam_endpoint_engine.sv
// MPLS-TP OAM endpoint: PDU classification, counters, stickies, CPU copy, LOC.
// Assumes the pipeline presents one validated descriptor per cycle and a
// timer tick from the continuity_loss_timer_unit per expected Rx interval.
//
// Contract
// - Looped OAM PDUs leave with internal_header_hop_limit set to one.
// - Eight-entry shared generic_type_table; matches classify as generic.
// - Each valid PDU bumps exactly one of four direction/select counters.
// - Received generic PDU sets its bit in generic_type_seen_flags.
// - Received generic PDU copied to CPU when its copy-mask bit set.
// - Neither BFD nor generic channel type classifies as unknown.
// - Received unknown PDU sets unknown_type_seen_flag.
// - Received unknown PDU goes to default CPU queue when copy enabled.
// - mpls_oam_select high selects MPLS register groups over Ethernet.
// - endpoint_enable low: registers writable, frames untouched.
// - up_direction_select picks up-facing or down-facing endpoint.
// - Local BFD state and diagnostic are software-only registers.
// - No source-identifier TLV or authentication checks in hardware.
// - Types 0x7 and 0x22 are CC, 0x23 is CV.
// - cc_type_select chooses which CC channel type is detected.
// - Valid CC or CV PDUs of the function in charge clear the loss-of-continuity counter.
// - Received CV PDUs always copied to the CPU.
// - Coordinated: source ticks, source clears, event at source multiplier.
// - Independent: sink ticks, sink clears, only sink raises event.
// - Coordinated uses source only; independent uses sink only.
// - Rx sampling stores multiplier of latest valid CC as threshold.
// - coordinated_mode_select one is coordinated, zero independent.
`timescale 1ns/10ps
`default_nettype none

module oam_endpoint_engine
  import oam_ep_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pdu_in_t     pdu_in,
  input  wire logic        src_tick,
  input  wire logic        sink_tick,
  output pdu_out_t         pdu_out,
  output logic             up_direction_select,
  output logic             mpls_oam_select
);

  logic [31:0] ctrl_r, cnt_sel_r, copy_r, bfd_cfg_r, sticky_r;
  logic [31:0] rx_sel_r, rx_nsel_r, tx_sel_r, tx_nsel_r;
  logic [15:0] generic_type_table [GEN_ENTRIES];
  logic [1:0]  src_lstate_r, sink_lstate_r, src_rstate_r, sink_rstate_r;
  logic [4:0]  src_ldiag_r, sink_ldiag_r, src_rdiag_r, sink_rdiag_r;
  logic [7:0]  remote_multiplier_source, sink_rdm_r, loc_cnt_r;
  logic [7:0]  hop_nxt;

  logic       wr_en, rd_en, endpoint_enable, coord;
  logic       is_gen, is_cc, is_cv, rx_frm, tx_frm, sel_hit, loc_hit, own_fn;
  logic [7:0] gen_hit;
  logic [15:0] cc_type;
  pdu_class_t cls;

  // APB answers in the access cycle; no wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = clk_en & psel & penable & pwrite;
  assign rd_en   = clk_en & psel & ~penable & ~pwrite;

  assign endpoint_enable     = ctrl_r[CTRL_ENA_BIT];
  assign up_direction_select = ctrl_r[CTRL_UP_BIT];
  assign mpls_oam_select     = ctrl_r[CTRL_MPLS_BIT];
  assign coord               = bfd_cfg_r[CFG_COORD_BIT];

  // Channel-type detection; only the selected CC value counts as CC
  assign cc_type = bfd_cfg_r[CFG_CC6428_BIT] ? CT_CC_6428 : CT_CC_5885;
  assign is_cc   = (pdu_in.chan_type == cc_type);
  assign is_cv   = (pdu_in.chan_type == CT_CV_6428);

  // Table lookup, one comparator per entry
  genvar g;
  generate
    for (g = 0; g < GEN_ENTRIES; g++) begin : g_gen
      assign gen_hit[g] = (pdu_in.chan_type == generic_type_table[g]);
    end
  endgenerate
  assign is_gen = |gen_hit;

  // Frames are processed only when enabled and in MPLS mode
  assign rx_frm = pdu_in.valid & pdu_in.pdu_ok & endpoint_enable & mpls_oam_select
                & ~pdu_in.is_tx;
  assign tx_frm = pdu_in.valid & pdu_in.pdu_ok & endpoint_enable & mpls_oam_select
                & pdu_in.is_tx;

  // Classification priority: BFD before generic before unknown
  always_comb begin
    if (!(rx_frm | tx_frm))
      cls = CLS_NONE;
    else if (is_cc)
      cls = CLS_CC;
    else if (is_cv)
      cls = CLS_CV;
    else if (is_gen)
      cls = CLS_GEN;
    else
      cls = CLS_UNK;
  end

  always_comb begin
    case (cls)
      CLS_CC:  sel_hit = cnt_sel_r[SEL_CC_BIT];
      CLS_CV:  sel_hit = cnt_sel_r[SEL_CV_BIT];
      CLS_GEN: sel_hit = cnt_sel_r[SEL_GEN_BIT];
      CLS_UNK: sel_hit = cnt_sel_r[SEL_UNK_BIT];
      default: sel_hit = 1'b0;
    endcase
  end

  // In coordinated mode only the source function carries the session
  assign own_fn  = coord ? ~pdu_in.sink_fn : pdu_in.sink_fn;
  // Threshold comes from the remote multiplier of the function in charge
  assign loc_hit = coord ? (loc_cnt_r + 8'h01 >= remote_multiplier_source)
                         : (loc_cnt_r + 8'h01 >= sink_rdm_r);

  // Configuration writes; accepted whether or not the endpoint is enabled
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r        <= RST_ZERO;
      cnt_sel_r     <= RST_ZERO;
      copy_r        <= RST_ZERO;
      bfd_cfg_r     <= RST_ZERO;
      src_lstate_r  <= 2'h0;
      sink_lstate_r <= 2'h0;
      src_ldiag_r   <= 5'h00;
      sink_ldiag_r  <= 5'h00;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL:    ctrl_r    <= pwdata;
        OFS_CNT_SEL: cnt_sel_r <= pwdata;
        OFS_COPY:    copy_r    <= pwdata;
        OFS_BFD_CFG: bfd_cfg_r <= pwdata;
        // Local state and diagnostic change only here, never from frames
        OFS_SRC_INFO: begin
          src_lstate_r <= pwdata[1:0];
          src_ldiag_r  <= pwdata[6:2];
        end
        OFS_SINK_INFO: begin
          sink_lstate_r <= pwdata[1:0];
          sink_ldiag_r  <= pwdata[6:2];
        end
        default: ;
      endcase
    end
  end

  // Shared generic table
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < GEN_ENTRIES; i++)
        generic_type_table[i] <= RST_CT;
    end else if (wr_en && paddr[11:5] == OFS_GEN_BASE[11:5]) begin
      generic_type_table[paddr[4:2]] <= pwdata[15:0];
    end
  end

  // Sticky flags: frame set wins over write-one-to-clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sticky_r <= RST_ZERO;
    end else if (clk_en) begin
      for (int i = 0; i < 32; i++) begin
        if (i < GEN_ENTRIES && cls == CLS_GEN && rx_frm && gen_hit[i[2:0]])
          sticky_r[i] <= 1'b1;
        else if (i == STK_UNK_BIT && cls == CLS_UNK && rx_frm)
          sticky_r[i] <= 1'b1;
        else if (i == STK_LOC_BIT && src_tick_sel() && loc_hit && endpoint_enable)
          sticky_r[i] <= 1'b1;
        else if (wr_en && paddr == OFS_STICKY && pwdata[i])
          sticky_r[i] <= 1'b0;
      end
    end
  end

  function automatic logic src_tick_sel();
    return coord ? src_tick : sink_tick;
  endfunction : src_tick_sel

  // Counters: exactly one per valid processed PDU
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_sel_r  <= RST_ZERO;
      rx_nsel_r <= RST_ZERO;
      tx_sel_r  <= RST_ZERO;
      tx_nsel_r <= RST_ZERO;
    end else if (clk_en && cls != CLS_NONE) begin
      case ({pdu_in.is_tx, sel_hit})
        2'b01:   rx_sel_r  <= rx_sel_r + 32'h1;
        2'b00:   rx_nsel_r <= rx_nsel_r + 32'h1;
        2'b11:   tx_sel_r  <= tx_sel_r + 32'h1;
        default: tx_nsel_r <= tx_nsel_r + 32'h1;
      endcase
    end
  end

  // Remote info sampled from valid received CC; authentication not checked
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      src_rstate_r <= 2'h0;
      src_rdiag_r  <= 5'h00;
      remote_multiplier_source <= RST_DM;
      sink_rstate_r <= 2'h0;
      sink_rdiag_r  <= 5'h00;
      sink_rdm_r    <= RST_DM;
    end else if (clk_en && rx_frm && cls == CLS_CC && bfd_cfg_r[CFG_SAMPLE_BIT]) begin
      if (pdu_in.sink_fn) begin
        sink_rstate_r <= pdu_in.sta;
        sink_rdiag_r  <= pdu_in.diag;
        sink_rdm_r    <= pdu_in.dm;
      end else begin
        src_rstate_r <= pdu_in.sta;
        src_rdiag_r  <= pdu_in.diag;
        remote_multiplier_source <= pdu_in.dm;
      end
    end
  end

  // LOC counter: clear on valid CC/CV of the function in charge, else tick
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      loc_cnt_r <= 8'h00;
    end else if (clk_en && endpoint_enable) begin
      if (rx_frm && (cls == CLS_CC || cls == CLS_CV) && own_fn)
        loc_cnt_r <= 8'h00;
      else if (src_tick_sel() && loc_hit)
        loc_cnt_r <= 8'h00;
      else if (src_tick_sel())
        loc_cnt_r <= loc_cnt_r + 8'h01;
    end
  end

  // Loopback rewrites hop limit; other frames keep theirs
  assign hop_nxt = pdu_in.loop ? HOP_LIMIT_LOOP : pdu_in.hop_limit;

  // Registered per-frame result; the block never creates a frame itself
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pdu_out <= '0;
    end else if (clk_en) begin
      pdu_out.valid         <= rx_frm | tx_frm;
      pdu_out.hop_limit     <= hop_nxt;
      pdu_out.cpu_copy      <= rx_frm & ((cls == CLS_CV)
                             | (cls == CLS_GEN && |(gen_hit & copy_r[7:0])));
      pdu_out.default_queue <= rx_frm & (cls == CLS_UNK) & copy_r[COPY_UNK_BIT];
      pdu_out.loc_event     <= endpoint_enable & src_tick_sel() & loc_hit;
    end
  end

  // Read mux, data registered in the setup cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= RST_ZERO;
    end else if (rd_en) begin
      case (paddr)
        OFS_CTRL:      prdata <= ctrl_r;
        OFS_CNT_SEL:   prdata <= cnt_sel_r;
        OFS_COPY:      prdata <= copy_r;
        OFS_BFD_CFG:   prdata <= bfd_cfg_r;
        OFS_STICKY:    prdata <= sticky_r;
        OFS_RX_SEL:    prdata <= rx_sel_r;
        OFS_RX_NSEL:   prdata <= rx_nsel_r;
        OFS_TX_SEL:    prdata <= tx_sel_r;
        OFS_TX_NSEL:   prdata <= tx_nsel_r;
        OFS_SRC_INFO:  prdata <= {8'h00, remote_multiplier_source, 2'h0,
                                  src_rdiag_r, src_rstate_r, src_ldiag_r, src_lstate_r};
        OFS_SINK_INFO: prdata <= {8'h00, sink_rdm_r, 2'h0,
                                  sink_rdiag_r, sink_rstate_r, sink_ldiag_r, sink_lstate_r};
        OFS_LOC:       prdata <= {24'h0, loc_cnt_r};
        default: begin
          if (paddr[11:5] == OFS_GEN_BASE[11:5])
            prdata <= {16'h0, generic_type_table[paddr[4:2]]};
          else
            prdata <= RST_ZERO;
        end
      endcase
    end
  end

  // Exactly one counter moves per processed PDU
  AST_ONE_COUNT: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && cls != CLS_NONE) |=> (($countones({rx_sel_r != $past(rx_sel_r),
      rx_nsel_r != $past(rx_nsel_r), tx_sel_r != $past(tx_sel_r),
      tx_nsel_r != $past(tx_nsel_r)})) == 1))
    else $error("PDU did not move exactly one counter");

  AST_DISABLED_IDLE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && !endpoint_enable) |=> !pdu_out.valid)
    else $error("frame processed while endpoint disabled");

  AST_LOOP_HOP: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && pdu_in.loop) |=> pdu_out.hop_limit == HOP_LIMIT_LOOP)
    else $error("looped PDU hop limit not one");

  AST_UNK_STICKY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && rx_frm && cls == CLS_UNK) |=> sticky_r[STK_UNK_BIT])
    else $error("unknown type flag not set");

  AST_GEN_STICKY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && rx_frm && cls == CLS_GEN) |=> ((sticky_r[7:0] & $past(gen_hit)) != 8'h00))
    else $error("generic type flag not set");

  AST_CV_COPY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && rx_frm && cls == CLS_CV) |=> pdu_out.cpu_copy)
    else $error("CV PDU not copied to CPU");

  AST_UNK_QUEUE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && rx_frm) |=> (pdu_out.default_queue ==
      ($past(cls) == CLS_UNK && $past(copy_r[COPY_UNK_BIT]))))
    else $error("unknown PDU queue copy wrong");

  AST_LOC_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && endpoint_enable && rx_frm && own_fn && (cls == CLS_CC || cls == CLS_CV))
      |=> loc_cnt_r == 8'h00)
    else $error("valid CC/CV did not clear LOC counter");

  AST_SINK_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && !coord && !sink_tick) |=> !pdu_out.loc_event)
    else $error("LOC event without sink tick in independent mode");

  // Coordinated mode: only a source tick may raise the event
  AST_SRC_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && coord && !src_tick) |=> !pdu_out.loc_event)
    else $error("LOC event without source tick in coordinated mode");

  // Event, sticky and counter restart all follow the threshold tick
  AST_LOC_EVENT: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && endpoint_enable && (coord ? src_tick : sink_tick) && loc_hit)
      |=> (pdu_out.loc_event && sticky_r[STK_LOC_BIT] && loc_cnt_r == 8'h00))
    else $error("threshold tick did not raise LOC event");

  // Generic copies follow the copy mask of the matching entries
  AST_GEN_COPY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && rx_frm && cls == CLS_GEN) |=>
      (pdu_out.cpu_copy == ($past(gen_hit & copy_r[7:0]) != 8'h00)))
    else $error("generic PDU copy does not follow mask");

  // Transmitted PDUs are counted only, never copied
  AST_TX_NO_COPY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && tx_frm) |=> (!pdu_out.cpu_copy && !pdu_out.default_queue))
    else $error("transmitted PDU copied to CPU");

  // Local state and diagnostic move only on a software write
  AST_SRC_LOCAL: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(wr_en && paddr == OFS_SRC_INFO) |=> ($stable(src_lstate_r) && $stable(src_ldiag_r)))
    else $error("source local state changed without a write");

  AST_SINK_LOCAL: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(wr_en && paddr == OFS_SINK_INFO) |=> ($stable(sink_lstate_r) && $stable(sink_ldiag_r)))
    else $error("sink local state changed without a write");

  // A low clock enable freezes counters, flags and outputs alike
  AST_FROZEN: assert property (@(posedge ref_clk) disable iff (!rstn)
    !clk_en |=> ($stable(rx_sel_r) && $stable(tx_sel_r) && $stable(sticky_r)
      && $stable(loc_cnt_r) && $stable(pdu_out) && $stable(prdata)))
    else $error("state moved while clock enable low");

endmodule : oam_endpoint_engine

`default_nettype wire

//--- include/oam_ep_pkg.sv
// Constants, register map and frame carriers for the MPLS-TP OAM endpoint.
// Assumes a 32-bit APB slave interface and a single 125 MHz clock domain.
package oam_ep_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_CNT_SEL   = 12'h004;
  localparam logic [11:0] OFS_COPY      = 12'h008;
  localparam logic [11:0] OFS_BFD_CFG   = 12'h00C;
  localparam logic [11:0] OFS_STICKY    = 12'h010;
  localparam logic [11:0] OFS_RX_SEL    = 12'h014;
  localparam logic [11:0] OFS_RX_NSEL   = 12'h018;
  localparam logic [11:0] OFS_TX_SEL    = 12'h01C;
  localparam logic [11:0] OFS_TX_NSEL   = 12'h020;
  localparam logic [11:0] OFS_SRC_INFO  = 12'h024;
  localparam logic [11:0] OFS_SINK_INFO = 12'h028;
  localparam logic [11:0] OFS_LOC       = 12'h02C;
  localparam logic [11:0] OFS_GEN_BASE  = 12'h040;

  // Control register bit positions
  localparam int CTRL_ENA_BIT  = 0;
  localparam int CTRL_UP_BIT   = 1;
  localparam int CTRL_MPLS_BIT = 2;
  // Count-select bit positions
  localparam int SEL_CC_BIT    = 0;
  localparam int SEL_CV_BIT    = 1;
  localparam int SEL_GEN_BIT   = 2;
  localparam int SEL_UNK_BIT   = 3;
  // BFD config bit positions
  localparam int CFG_CC6428_BIT = 0;
  localparam int CFG_COORD_BIT  = 1;
  localparam int CFG_SAMPLE_BIT = 2;
  localparam int CFG_SINK_RX_BIT = 3;
  // Copy register: generic mask in [7:0], unknown enable at bit 8
  localparam int COPY_UNK_BIT  = 8;
  localparam int STK_UNK_BIT   = 8;
  localparam int STK_LOC_BIT   = 9;

  // Channel types and table size
  localparam int          GEN_ENTRIES = 8;
  localparam logic [15:0] CT_CC_5885  = 16'h0007;
  localparam logic [15:0] CT_CC_6428  = 16'h0022;
  localparam logic [15:0] CT_CV_6428  = 16'h0023;
  localparam logic [7:0]  HOP_LIMIT_LOOP = 8'h01;

  // Reset values
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  localparam logic [15:0] RST_CT      = 16'h0000;
  localparam logic [7:0]  RST_DM      = 8'h03;

  typedef enum {CLS_NONE, CLS_CC, CLS_CV, CLS_GEN, CLS_UNK} pdu_class_t;

  // Frame descriptor from the switch pipeline
  typedef struct packed {
    logic        valid;
    logic        is_tx;
    logic        loop;
    logic        pdu_ok;
    logic        sink_fn;
    logic [15:0] chan_type;
    logic [1:0]  sta;
    logic [4:0]  diag;
    logic [7:0]  dm;
    logic [7:0]  hop_limit;
  } pdu_in_t;

  // Per-frame result towards pipeline and extraction path
  typedef struct packed {
    logic        valid;
    logic        cpu_copy;
    logic        default_queue;
    logic        loc_event;
    logic [7:0]  hop_limit;
  } pdu_out_t;

endpackage : oam_ep_pkg

//--- testbench/pipeline_model.sv
// Switch frame pipeline as seen by the endpoint: turns a bench request into a one-cycle descriptor.
// Assumes the bench raises req.valid for exactly the cycles in which a frame is offered.
`timescale 1ns/10ps
`default_nettype none

module pipeline_model
  import oam_ep_pkg::*;
(
  input  wire logic    ref_clk,
  input  wire pdu_in_t req,
  output var pdu_in_t  pdu_in
);
  initial pdu_in = '0;

  // Between frames every field but valid flips, so a stale descriptor never repeats unnoticed
  always @(posedge ref_clk) begin
    if (req.valid) begin
      pdu_in <= req;
    end else begin
      pdu_in <= {1'b0, ~pdu_in[$bits(pdu_in_t)-2:0]};
    end
  end
endmodule : pipeline_model

`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the OAM endpoint engine: APB set-up, PDU traffic, loss-of-continuity.
// Assumes the package and the pipeline model are compiled first; one 125 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import oam_ep_pkg::*;
  logic        ref_clk, rstn, clk_en, psel, penable, pwrite, src_tick, sink_tick;
  logic        pready, pslverr, up_sel, mpls_sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] gt [8];
  pdu_in_t     req, pdu_in;
  pdu_out_t    pdu_out;
  logic [31:0] rd_q [$];
  logic [3:0]  out_q [$];
  int          n_errors, samples_checked, n_loc, i;
  // Generic entries 0, 2, 5 and 7 are copied to the CPU
  localparam logic [7:0] GEN_COPY_MASK = 8'hA5;

  oam_endpoint_engine oam_endpoint_engine_inst (
    .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pdu_in(pdu_in), .src_tick(src_tick), .sink_tick(sink_tick),
    .pdu_out(pdu_out), .up_direction_select(up_sel), .mpls_oam_select(mpls_sel));

  pipeline_model pipeline_model_inst (.ref_clk(ref_clk), .req(req), .pdu_in(pdu_in));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // Setup cycle, then hold everything until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never re-drives psel in this time step
    @(posedge ref_clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // e = {result expected, cpu copy compared, cpu copy, default queue}
  task automatic pdu(input logic tx, input logic lp, input logic sk, input logic [15:0] ct,
                     input logic [7:0] dm, input logic [3:0] e);
    req <= '{valid: 1'b1, is_tx: tx, loop: lp, pdu_ok: 1'b1, sink_fn: sk, chan_type: ct,
             sta: 2'h2, diag: 5'h05, dm: dm, hop_limit: 8'($urandom())};
    if (e[3]) out_q.push_back({lp, e[2:0]});
    @(posedge ref_clk);
  endtask : pdu

  task automatic idle;
    req.valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : idle

  task automatic tick(input logic snk, input int n);
    repeat (n) begin
      src_tick  <= ~snk;
      sink_tick <= snk;
      @(posedge ref_clk);
      src_tick  <= 1'b0;
      sink_tick <= 1'b0;
      @(posedge ref_clk);
    end
    repeat (3) @(posedge ref_clk);
  endtask : tick

  // Results are matched against the oldest note as they appear
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite) check(prdata, rd_q.pop_front());
    if (pdu_out.loc_event === 1'b1) n_loc++;
    if (pdu_out.valid === 1'b1) begin
      if (out_q.size() == 0) begin
        check(pdu_out.valid, 1'b0);
      end else begin
        logic [3:0] e;
        e = out_q.pop_front();
        check(pdu_out.default_queue, e[0]);
        if (e[2]) check(pdu_out.cpu_copy, e[1]);
        if (e[3]) check(pdu_out.hop_limit, HOP_LIMIT_LOOP);
      end
    end
  end

  // Whole run is well under 2000 cycles
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end

  initial begin
    {rstn, psel, penable, pwrite, src_tick, sink_tick, paddr, pwdata} = '0;
    req = '0;
    clk_en = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    n_loc = 0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    void'($urandom(95));
    rd(OFS_SRC_INFO, 32'h0003_0000);
    rd(12'h100, 32'h0000_0000);
    for (i = 0; i < 12; i++) apb(1'b1, 12'(i * 4), 32'h0000_0000);
    pdu(1'b0, 1'b0, 1'b0, CT_CV_6428, 8'h02, 4'h0);
    idle();
    rd(OFS_RX_SEL, 32'h0000_0000);
    $display("test reset_and_disabled done");
    for (i = 0; i < GEN_ENTRIES; i++) begin
      gt[i] = 16'h0100 + 16'(i * 16) + 16'($urandom() % 16);
      apb(1'b1, OFS_GEN_BASE + 12'(i * 4), {16'h0000, gt[i]});
    end
    apb(1'b1, OFS_CNT_SEL, 32'h0000_0007);
    apb(1'b1, OFS_COPY, {23'h000000, 1'b1, GEN_COPY_MASK});
    apb(1'b1, OFS_BFD_CFG, 32'h0000_0006);
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    check({up_sel, mpls_sel}, 2'b11);
    pdu(1'b0, 1'b0, 1'b0, CT_CC_5885, 8'h02, 4'hC);
    pdu(1'b0, 1'b0, 1'b0, CT_CV_6428, 8'h02, 4'hE);
    pdu(1'b0, 1'b0, 1'b0, CT_CC_6428, 8'h02, 4'h9);
    for (i = 0; i < GEN_ENTRIES; i++) begin
      pdu(1'b0, 1'b0, 1'b0, gt[i], 8'h02, {2'b11, GEN_COPY_MASK[i], 1'b0});
    end
    pdu(1'b0, 1'b0, 1'b0, 16'h0055, 8'h02, 4'h9);
    pdu(1'b1, 1'b1, 1'b0, CT_CC_5885, 8'h02, 4'hC);
    pdu(1'b1, 1'b0, 1'b0, 16'h0055, 8'h02, 4'hC);
    idle();
    rd(OFS_RX_SEL, 32'd10);
    rd(OFS_RX_NSEL, 32'd2);
    rd(OFS_TX_SEL, 32'd1);
    rd(OFS_TX_NSEL, 32'd1);
    rd(OFS_STICKY, 32'h0000_01FF);
    apb(1'b1, OFS_STICKY, 32'h0000_01FF);
    rd(OFS_STICKY, 32'h0000_0000);
    apb(1'b1, OFS_SRC_INFO, 32'h0000_007F);
    rd(OFS_SRC_INFO, 32'h0002_0B7F);
    $display("test classify_and_count done");
    tick(1'b0, 2);
    check(n_loc, 1);
    rd(OFS_STICKY, 32'h0000_0200);
    tick(1'b0, 1);
    pdu(1'b0, 1'b0, 1'b0, CT_CC_5885, 8'h02, 4'hC);
    idle();
    tick(1'b0, 1);
    check(n_loc, 1);
    rd(OFS_LOC, 32'h0000_0001);
    $display("test coordinated_loc done");
    apb(1'b1, OFS_BFD_CFG, 32'h0000_0004);
    pdu(1'b0, 1'b0, 1'b1, CT_CC_5885, 8'h03, 4'hC);
    idle();
    tick(1'b0, 3);
    check(n_loc, 1);
    // Clock enable low: a sink tick must not advance anything
    clk_en <= 1'b0;
    tick(1'b1, 1);
    clk_en <= 1'b1;
    check(n_loc, 1);
    rd(OFS_LOC, 32'h0000_0000);
    tick(1'b1, 2);
    check(n_loc, 1);
    tick(1'b1, 1);
    check(n_loc, 2);
    check(out_q.size(), 0);
    $display("test independent_loc done");
    complete_run();
  end
endmodule : testbench

`default_nettype wire
